// *** rtl/sbrg_pkg.sv ***
package sbrg_pkg;

	// Bus and counter widths
	localparam int APB_AW  = 8;
	localparam int TIMER_W = 16;
	localparam int PRESC_W = 6;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL_FIRST  = 8'h00;
	localparam logic [7:0] ADDR_CTRL_SECOND = 8'h04;
	localparam logic [7:0] ADDR_RX_STATUS   = 8'h08;
	localparam logic [7:0] ADDR_DIV_LOW     = 8'h0c;
	localparam logic [7:0] ADDR_DIV_HIGH    = 8'h10;
	localparam logic [7:0] ADDR_TX_STATUS   = 8'h14;

	// Field positions in the baud control and transmit registers
	localparam int CTRL_IDLE_BIT = 6;
	localparam int CTRL_WIDE_BIT = 3;
	localparam int TX_SYNC_BIT   = 4;
	localparam int TX_HS_BIT     = 2;

	// Writable bits and constant read bits
	localparam logic [7:0] TX_RW_MASK    = 8'hfd;
	localparam logic [7:0] TX_EMPTY_MASK = 8'h02;
	localparam logic [7:0] RX_RW_MASK    = 8'hf8;

	// Values after reset
	localparam logic [7:0] RST_TX   = 8'h00;
	localparam logic [7:0] RST_RX   = 8'h00;
	localparam logic [7:0] RST_DIV  = 8'h00;
	localparam logic       RST_WIDE = 1'b0;
	localparam logic       RST_IDLE = 1'b1;

	// Prescaler limits: clock multiplier minus one
	localparam logic [5:0] PRESC_LIM_64 = 6'h3f;
	localparam logic [5:0] PRESC_LIM_16 = 6'h0f;
	localparam logic [5:0] PRESC_LIM_4  = 6'h03;

endpackage

// *** rtl/sbrg_period_counter.sv ***
`timescale 1ns/1ps
`default_nettype none

module sbrg_period_counter #(
	parameter int W = 16
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         enable,
	input  wire logic         clear,
	input  wire logic [W-1:0] limit,
	output logic      [W-1:0] count,
	output logic              tick
);

	typedef struct packed {
		logic [W-1:0] count;
		logic         tick;
	} sbrg_cnt_state_t;

	sbrg_cnt_state_t st;
	sbrg_cnt_state_t next_st;

	// Count up to the limit, wrap to zero and flag the wrap
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (clear) begin
			next_st.count = '0;
		end else if (enable) begin
			if (st.count >= limit) begin
				next_st.count = '0;
				next_st.tick = 1'b1;
			end else begin
				next_st.count = st.count + {{(W-1){1'b0}}, 1'b1};
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign count = st.count;
	assign tick  = st.tick;

	// Helper: cycles since last tick, valid only over undisturbed periods
	logic [W:0] gap;
	logic       steady;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			gap <= '0;
			steady <= 1'b0;
		end else begin
			gap <= st.tick ? {{W{1'b0}}, 1'b1} : gap + {{W{1'b0}}, 1'b1};
			if (clear || !enable || limit != $past(limit)) begin
				steady <= 1'b0;
			end else if (st.tick) begin
				steady <= 1'b1;
			end
		end
	end

	wrap_to_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
		enable && !clear && st.count >= limit |=> st.count == '0 && st.tick)
		else $error("Counter did not wrap at its limit");

	clear_zeroes_a: assert property (@(posedge ref_clk) disable iff (rst)
		clear |=> st.count == '0 && !st.tick)
		else $error("Clear did not zero the counter");

	tick_period_a: assert property (@(posedge ref_clk) disable iff (rst)
		st.tick && steady && enable && !clear && limit == $past(limit)
		|-> gap == {1'b0, limit} + {{W{1'b0}}, 1'b1})
		else $error("Tick spacing differs from limit plus one");

endmodule

`default_nettype wire

// *** rtl/sbrg_rate_generator.sv ***
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - The rate timer is a dedicated counter that runs 8 or 16 bits wide and serves both serial modes.
// - After reset the timer runs 8 bits wide with the wide divider select cleared.
// - Setting the wide divider select switches the timer to 16 bits using both divisor bytes.
// - The free-running timer period is set by the divisor n from the low divisor byte in 8-bit width, or from both divisor bytes in 16-bit width.
// - In 16-bit width the high divisor byte holds the upper eight bits of n and the low byte the lower eight.
// - In asynchronous mode the multiplier follows both high speed select and wide divider select.
// - In synchronous mode high speed select has no effect on the period.
// - Any write to either divisor byte with the low byte strobe set clears the timer at once.
// - Asynchronous 8-bit low speed gives a bit rate of the clock over 64 times n plus one.
// - Asynchronous 16-bit low speed gives a bit rate of the clock over 16 times n plus one.
// - Synchronous mode in either width gives a bit clock of the clock over 4 times n plus one.
// - The receive idle flag reads 0 while a reception runs and 1 while the receiver is idle.
module sbrg_rate_generator (
	input  wire logic                         ref_clk,
	input  wire logic                         rst,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [sbrg_pkg::APB_AW-1:0]  paddr,
	input  wire logic [31:0]                  pwdata,
	input  wire logic [3:0]                   pstrb,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic                         receive_active,
	output logic                              timer_tick,
	output logic                              baud_tick
);

	typedef struct packed {
		logic        wide;
		logic        idle;
		logic [7:0]  rx_ctrl;
		logic [7:0]  tx_ctrl;
		logic [7:0]  div_low;
		logic [7:0]  div_high;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} sbrg_state_t;

	sbrg_state_t st;
	sbrg_state_t next_st;

	logic                         commit;
	logic                         wr_commit;
	logic                         div_write;
	logic                         addr_hit;
	logic [7:0]                   read_byte;
	logic                         sync_mode;
	logic                         high_speed;
	logic [sbrg_pkg::TIMER_W-1:0] timer_limit;
	logic [sbrg_pkg::PRESC_W-1:0] presc_limit;
	logic [sbrg_pkg::TIMER_W-1:0] timer_count;
	logic                         timer_wrap;

	// Mode bits taken from the transmit control register
	assign sync_mode  = st.tx_ctrl[sbrg_pkg::TX_SYNC_BIT];
	assign high_speed = st.tx_ctrl[sbrg_pkg::TX_HS_BIT];

	// Transfer completes at the edge where the registered ready is seen
	assign commit    = psel && penable && st.pready;
	assign wr_commit = commit && pwrite && pstrb[0];
	assign div_write = wr_commit && (paddr == sbrg_pkg::ADDR_DIV_LOW || paddr == sbrg_pkg::ADDR_DIV_HIGH);

	// Address decode and read mux
	always_comb begin
		addr_hit = 1'b1;
		read_byte = 8'h00;
		unique case (paddr)
			sbrg_pkg::ADDR_CTRL_FIRST, sbrg_pkg::ADDR_CTRL_SECOND: begin
				read_byte[sbrg_pkg::CTRL_IDLE_BIT] = st.idle;
				read_byte[sbrg_pkg::CTRL_WIDE_BIT] = st.wide;
			end
			sbrg_pkg::ADDR_RX_STATUS: begin
				read_byte = st.rx_ctrl;
			end
			sbrg_pkg::ADDR_DIV_LOW: begin
				read_byte = st.div_low;
			end
			sbrg_pkg::ADDR_DIV_HIGH: begin
				read_byte = st.div_high;
			end
			sbrg_pkg::ADDR_TX_STATUS: begin
				read_byte = st.tx_ctrl | sbrg_pkg::TX_EMPTY_MASK;
			end
			default: begin
				addr_hit = 1'b0;
			end
		endcase
	end

	// Timer limit: both bytes when wide, low byte alone otherwise
	always_comb begin
		if (st.wide) begin
			timer_limit = {st.div_high, st.div_low};
		end else begin
			timer_limit = {8'h00, st.div_low};
		end
	end

	// Clock multiplier selection
	always_comb begin
		if (sync_mode) begin
			presc_limit = sbrg_pkg::PRESC_LIM_4;
		end else begin
			unique case ({st.wide, high_speed})
				2'b00: presc_limit = sbrg_pkg::PRESC_LIM_64;
				2'b01: presc_limit = sbrg_pkg::PRESC_LIM_16;
				2'b10: presc_limit = sbrg_pkg::PRESC_LIM_16;
				2'b11: presc_limit = sbrg_pkg::PRESC_LIM_4;
			endcase
		end
	end

	// Register file and bus answer
	always_comb begin
		next_st = st;
		next_st.idle = !receive_active;
		if (psel && penable && !st.pready) begin
			next_st.pready = 1'b1;
			next_st.pslverr = !addr_hit;
			next_st.prdata = {24'h000000, read_byte};
		end else begin
			next_st.pready = 1'b0;
			next_st.pslverr = 1'b0;
		end
		if (wr_commit) begin
			unique case (paddr)
				sbrg_pkg::ADDR_CTRL_FIRST, sbrg_pkg::ADDR_CTRL_SECOND: begin
					next_st.wide = pwdata[sbrg_pkg::CTRL_WIDE_BIT];
				end
				sbrg_pkg::ADDR_RX_STATUS: begin
					next_st.rx_ctrl = pwdata[7:0] & sbrg_pkg::RX_RW_MASK;
				end
				sbrg_pkg::ADDR_DIV_LOW: begin
					next_st.div_low = pwdata[7:0];
				end
				sbrg_pkg::ADDR_DIV_HIGH: begin
					next_st.div_high = pwdata[7:0];
				end
				sbrg_pkg::ADDR_TX_STATUS: begin
					next_st.tx_ctrl = pwdata[7:0] & sbrg_pkg::TX_RW_MASK;
				end
				default: begin
					next_st.wide = st.wide;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st.wide <= sbrg_pkg::RST_WIDE;
			st.idle <= sbrg_pkg::RST_IDLE;
			st.rx_ctrl <= sbrg_pkg::RST_RX;
			st.tx_ctrl <= sbrg_pkg::RST_TX;
			st.div_low <= sbrg_pkg::RST_DIV;
			st.div_high <= sbrg_pkg::RST_DIV;
			st.pready <= 1'b0;
			st.pslverr <= 1'b0;
			st.prdata <= 32'h00000000;
		end else begin
			st <= next_st;
		end
	end

	assign prdata  = st.prdata;
	assign pready  = st.pready;
	assign pslverr = st.pslverr;

	// Period timer: 16 bits wide, upper byte held at zero in 8-bit width
	sbrg_period_counter #(
		.W(sbrg_pkg::TIMER_W)
	) u_timer (
		.ref_clk (ref_clk),
		.rst     (rst),
		.enable  (1'b1),
		.clear   (div_write),
		.limit   (timer_limit),
		.count   (timer_count),
		.tick    (timer_wrap)
	);

	// Multiplier stage stepped by each timer wrap
	sbrg_period_counter #(
		.W(sbrg_pkg::PRESC_W)
	) u_presc (
		.ref_clk (ref_clk),
		.rst     (rst),
		.enable  (timer_wrap),
		.clear   (div_write),
		.limit   (presc_limit),
		.count   (),
		.tick    (baud_tick)
	);

	assign timer_tick = timer_wrap;

	// Bus transfer steps
	sequence apb_setup_s;
		psel && !penable;
	endsequence

	sequence apb_wait_s;
		psel && penable && !pready;
	endsequence

	apb_answer_time_a: assert property (@(posedge ref_clk) disable iff (rst)
		apb_setup_s ##1 apb_wait_s |=> pready ##1 !pready)
		else $error("Bus answer not given in one wait cycle");

	reset_narrow_a: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(rst) |-> !st.wide && timer_limit[15:8] == 8'h00)
		else $error("Timer not narrow after reset");

	wide_select_a: assert property (@(posedge ref_clk) disable iff (rst)
		wr_commit && (paddr == sbrg_pkg::ADDR_CTRL_FIRST) && pwdata[3]
		|=> st.wide && timer_limit == {st.div_high, st.div_low})
		else $error("Wide select did not take both bytes");

	divisor_store_a: assert property (@(posedge ref_clk) disable iff (rst)
		wr_commit && paddr == sbrg_pkg::ADDR_DIV_HIGH
		|=> st.div_high == $past(pwdata[7:0]) ##1 (st.pready || st.div_high == $past(st.div_high)))
		else $error("High divisor byte not stored");

	narrow_limit_a: assert property (@(posedge ref_clk) disable iff (rst)
		!st.wide |-> timer_limit == {8'h00, st.div_low})
		else $error("High byte leaked into narrow limit");

	async_mult_a: assert property (@(posedge ref_clk) disable iff (rst)
		!sync_mode |-> presc_limit == (st.wide == high_speed ?
			(st.wide ? sbrg_pkg::PRESC_LIM_4 : sbrg_pkg::PRESC_LIM_64) : sbrg_pkg::PRESC_LIM_16))
		else $error("Asynchronous multiplier wrong");

	sync_mult_a: assert property (@(posedge ref_clk) disable iff (rst)
		sync_mode ##1 sync_mode && $changed(high_speed) |-> presc_limit == $past(presc_limit)
			&& presc_limit == sbrg_pkg::PRESC_LIM_4)
		else $error("High speed select changed synchronous rate");

	divisor_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
		div_write |=> timer_count == '0 && !baud_tick)
		else $error("Divisor write did not clear timer");

	idle_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
		receive_active |=> !st.idle ##1 (st.idle == !$past(receive_active)))
		else $error("Receive idle flag wrong");

	// Bus answer shape and refused accesses
	ready_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
		pready |=> !pready)
		else $error("Ready held for more than one cycle");

	error_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
		apb_setup_s ##1 apb_wait_s |=> pready && pslverr == !$past(addr_hit))
		else $error("Error response does not match the address");

	read_upper_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
		pready |-> prdata[31:8] == 24'h000000)
		else $error("Read data above the low byte not zero");

	unmapped_write_a: assert property (@(posedge ref_clk) disable iff (rst)
		wr_commit && !addr_hit |=> st.wide == $past(st.wide) && st.tx_ctrl == $past(st.tx_ctrl)
			&& st.div_low == $past(st.div_low) && st.div_high == $past(st.div_high))
		else $error("Write to an unmapped place changed a register");

	strobe_off_a: assert property (@(posedge ref_clk) disable iff (rst)
		commit && pwrite && !pstrb[0]
		|=> st.div_low == $past(st.div_low) && st.div_high == $past(st.div_high))
		else $error("Write without low strobe changed a divisor byte");

	// Divisor storage and timer limit
	low_store_a: assert property (@(posedge ref_clk) disable iff (rst)
		wr_commit && paddr == sbrg_pkg::ADDR_DIV_LOW |=> st.div_low == $past(pwdata[7:0]))
		else $error("Low divisor byte not stored");

	wide_limit_a: assert property (@(posedge ref_clk) disable iff (rst)
		st.wide |-> timer_limit == {st.div_high, st.div_low})
		else $error("Wide limit does not use both bytes");

	baud_on_wrap_a: assert property (@(posedge ref_clk) disable iff (rst)
		baud_tick |-> $past(timer_wrap))
		else $error("Baud tick without a timer wrap before it");

	// Clock multiplier per mode
	sync_rate_a: assert property (@(posedge ref_clk) disable iff (rst)
		sync_mode |-> presc_limit == sbrg_pkg::PRESC_LIM_4)
		else $error("Synchronous multiplier is not four");

	slow_narrow_a: assert property (@(posedge ref_clk) disable iff (rst)
		!sync_mode && !st.wide && !high_speed |-> presc_limit == sbrg_pkg::PRESC_LIM_64)
		else $error("Narrow low speed multiplier is not sixty four");

	slow_wide_a: assert property (@(posedge ref_clk) disable iff (rst)
		!sync_mode && st.wide && !high_speed |-> presc_limit == sbrg_pkg::PRESC_LIM_16)
		else $error("Wide low speed multiplier is not sixteen");

	fast_async_a: assert property (@(posedge ref_clk) disable iff (rst)
		!sync_mode && high_speed |-> presc_limit == (st.wide ? sbrg_pkg::PRESC_LIM_4 : sbrg_pkg::PRESC_LIM_16))
		else $error("High speed multiplier wrong");

endmodule

`default_nettype wire

// *** verification/test_serial_baud_rate_generator.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_serial_baud_rate_generator;
	logic                        ref_clk        = 1'b0;
	logic                        rst            = 1'b1;
	logic                        psel           = 1'b0;
	logic                        penable        = 1'b0;
	logic                        pwrite         = 1'b0;
	logic [sbrg_pkg::APB_AW-1:0] paddr          = '0;
	logic [31:0]                 pwdata         = '0;
	logic [3:0]                  pstrb          = 4'h0;
	logic                        receive_active = 1'b0;
	logic [31:0]                 prdata;
	logic                        pready;
	logic                        pslverr;
	logic                        timer_tick;
	logic                        baud_tick;
	int                          seed           = 2605;
	int                          n_fail         = 0;
	int                          checked        = 0;
	int                          cycles         = 0;
	logic [31:0]                 rd;
	logic                        err;
	int                          p;
	int                          n_exp;
	int                          m_exp;
	int                          lo;
	int                          hi;

	sbrg_rate_generator dut (
		.ref_clk        (ref_clk),
		.rst            (rst),
		.psel           (psel),
		.penable        (penable),
		.pwrite         (pwrite),
		.paddr          (paddr),
		.pwdata         (pwdata),
		.pstrb          (pstrb),
		.prdata         (prdata),
		.pready         (pready),
		.pslverr        (pslverr),
		.receive_active (receive_active),
		.timer_tick     (timer_tick),
		.baud_tick      (baud_tick)
	);

	// Clock source
	always #5 ref_clk = ~ref_clk;

	// Cycle ceiling against hangs
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 100000) begin
			n_fail++;
			conclude();
		end
	end

	// Compare and count
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	// Verdict and end of run
	task automatic conclude();
		if (n_fail == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// One APB transfer, held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
		int k;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'($random(seed)), d};
		pstrb   <= s;
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd  = prdata;
		err = pslverr;
		chk("pready", 32'(pready), 32'h1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	// Register write with random upper strobes
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d, {3'($random(seed)), 1'b1});
	endtask

	// Register read against an expected byte
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string name);
		apb(1'b0, a, 8'h00, 4'h0);
		chk(name, rd, {24'h0, e});
	endtask

	// Cycles between two successive pulses of the chosen tick
	task automatic period(input logic baud, output int per);
		int k;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while ((baud ? baud_tick : timer_tick) !== 1'b1 && k < 20000);
		per = 0;
		do begin
			@(posedge ref_clk);
			per++;
		end while ((baud ? baud_tick : timer_tick) !== 1'b1 && per < 20000);
	endtask

	// Part of a period, then a divisor write: both stages must count again from zero,
	// so the first baud tick comes M times n plus one cycles later, plus one for its flop
	task automatic restart(input logic [7:0] a, input logic [7:0] d, input int e);
		int k;
		repeat (100) @(posedge ref_clk);
		wr(a, d);
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (baud_tick !== 1'b1 && k < 200);
		chk("restart delay", 32'(k), 32'(e));
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		// Values after reset
		rdchk(sbrg_pkg::ADDR_CTRL_FIRST, 8'h40, "ctrl_first reset");
		rdchk(sbrg_pkg::ADDR_CTRL_SECOND, 8'h40, "ctrl_second reset");
		rdchk(sbrg_pkg::ADDR_RX_STATUS, 8'h00, "rx reset");
		rdchk(sbrg_pkg::ADDR_DIV_LOW, 8'h00, "div_low reset");
		rdchk(sbrg_pkg::ADDR_DIV_HIGH, 8'h00, "div_high reset");
		rdchk(sbrg_pkg::ADDR_TX_STATUS, 8'h02, "tx reset");
		// Unmapped place and access kinds
		apb(1'b0, 8'h18, 8'h00, 4'h0);
		chk("unmapped error", 32'(err), 32'h1);
		chk("unmapped data", rd, 32'h0);
		apb(1'b1, 8'h18, 8'hff, 4'hf);
		chk("unmapped write error", 32'(err), 32'h1);
		wr(sbrg_pkg::ADDR_TX_STATUS, 8'hff);
		rdchk(sbrg_pkg::ADDR_TX_STATUS, 8'hff, "tx ones");
		wr(sbrg_pkg::ADDR_TX_STATUS, 8'h00);
		rdchk(sbrg_pkg::ADDR_TX_STATUS, 8'h02, "tx zeros");
		wr(sbrg_pkg::ADDR_RX_STATUS, 8'hff);
		rdchk(sbrg_pkg::ADDR_RX_STATUS, 8'hf8, "rx ones");
		wr(sbrg_pkg::ADDR_CTRL_SECOND, 8'hff);
		rdchk(sbrg_pkg::ADDR_CTRL_FIRST, 8'h48, "ctrl alias");
		apb(1'b1, sbrg_pkg::ADDR_DIV_LOW, 8'h55, 4'h0);
		rdchk(sbrg_pkg::ADDR_DIV_LOW, 8'h00, "strobe off");
		// Receive idle flag follows the receiver
		receive_active <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rdchk(sbrg_pkg::ADDR_CTRL_FIRST, 8'h08, "idle busy");
		receive_active <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rdchk(sbrg_pkg::ADDR_CTRL_FIRST, 8'h48, "idle free");
		// Every mode, width and speed with a random divisor
		for (int i = 0; i < 8; i++) begin
			hi = $random(seed) & 1;
			lo = $random(seed) & 31;
			wr(sbrg_pkg::ADDR_TX_STATUS, {3'b000, i[2], 1'b0, i[0], 2'b00});
			wr(sbrg_pkg::ADDR_CTRL_FIRST, {4'h0, i[1], 3'b000});
			wr(sbrg_pkg::ADDR_DIV_HIGH, 8'(hi));
			wr(sbrg_pkg::ADDR_DIV_LOW, 8'(lo));
			rdchk(sbrg_pkg::ADDR_DIV_HIGH, 8'(hi), "div_high");
			rdchk(sbrg_pkg::ADDR_DIV_LOW, 8'(lo), "div_low");
			n_exp = i[1] ? hi * 256 + lo : lo;
			m_exp = i[2] ? 4 : (i[1] ? (i[0] ? 4 : 16) : (i[0] ? 16 : 64));
			period(1'b0, p);
			chk("timer period", 32'(p), 32'(n_exp + 1));
			period(1'b1, p);
			chk("baud period", 32'(p), 32'(m_exp * (n_exp + 1)));
		end
		// Divisor writes restart the timer, low byte then high byte
		wr(sbrg_pkg::ADDR_TX_STATUS, 8'h00);
		wr(sbrg_pkg::ADDR_CTRL_FIRST, 8'h00);
		wr(sbrg_pkg::ADDR_DIV_HIGH, 8'h00);
		wr(sbrg_pkg::ADDR_DIV_LOW, 8'h0c);
		restart(sbrg_pkg::ADDR_DIV_LOW, 8'h00, 64 * 1 + 1);
		wr(sbrg_pkg::ADDR_TX_STATUS, 8'h04);
		wr(sbrg_pkg::ADDR_CTRL_FIRST, 8'h08);
		wr(sbrg_pkg::ADDR_DIV_HIGH, 8'h00);
		wr(sbrg_pkg::ADDR_DIV_LOW, 8'h0c);
		restart(sbrg_pkg::ADDR_DIV_HIGH, 8'h00, 4 * 13 + 1);
		// Reset in mid-run returns to the narrow timer
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rdchk(sbrg_pkg::ADDR_CTRL_FIRST, 8'h40, "ctrl after reset");
		rdchk(sbrg_pkg::ADDR_DIV_LOW, 8'h00, "div_low after reset");
		conclude();
	end
endmodule

`default_nettype wire
